// >>> flash_array_model.sv
// behavioural flash array and macro sequencer facing the controller
`timescale 1ns/1ps
module flash_array_model
    import flash_ctl_pkg::*;
(
    input wire logic aclk,
    input wire logic arr_rd,
    input wire logic [20:0] arr_addr,
    output logic [127:0] arr_rdata,
    output flash_ctl_pkg::ecc_flags_s arr_ecc,
    input wire logic [3:0] ecc_inj,
    input wire logic macro_cmd_valid,
    input wire flash_ctl_pkg::cmd_word_s macro_cmd,
    input wire logic fail_inj,
    output logic macro_done,
    output logic macro_fail,
    output logic [31:0] macro_result
);
    import flash_ctl_pkg::*;
    logic [31:0] a32;
    logic [3:0] dly = 4'h0;
    logic [7:0] code = 8'h00;
    logic [127:0] junk = '0;
    // ========================================
    // array: data only while an access is open, churn otherwise so stale data never matches
    assign a32 = {11'h0, arr_addr};
    assign arr_rdata = arr_rd ? {a32 + 32'h3, a32 + 32'h2, a32 + 32'h1, a32} : junk;
    assign arr_ecc = arr_rd ? ecc_inj : junk[3:0];
    always_ff @(posedge aclk)
        junk <= ~junk;
    // ========================================
    // macro: fixed latency gives a visible busy window
    always_ff @(posedge aclk)
    begin
        if (macro_cmd_valid)
        begin
            dly <= 4'h6;
            code <= macro_cmd.command_code;
        end
        else if (dly != 4'h0)
            dly <= dly - 4'h1;
    end
    assign macro_done = (dly == 4'h1);
    assign macro_fail = macro_done ? fail_inj : junk[5];
    assign macro_result = macro_done ? {24'hc0de00, code} : junk[31:0];
endmodule

// >>> flash_controller.sv
// embedded flash command controller with axi4-lite register port
// What this block does
// - keeps a 512-byte signature store apart from the main array
// - code 0x14 drops ready, then maps the store onto the first 512 bytes
// - code 0x15 restores mapping, raises ready, fires interrupt if enabled
// - signature program copies the page buffer on code 0x12, then raises ready
// - signature program flags bad key and failed write verification
// - code 0x13 erases the store, flags failed erase verify or bad key
// - every array read is checked: single errors corrected, doubles detected
// - ecc events stay latched in status until status is read
// - four ecc flags: corrected and uncorrectable per 64-bit half
// - ecc flags may belong to a prefetched word; no address kept
// - registers at base 0x400e0a00: mode, command, status, result
// - mode bit 0 set gives an interrupt while ready
// - mode bits 11:8 plus one is the access length in cycles
// - mode bit 16 set disables sequential prefetch
// - mode bit 24 picks 128-bit or 64-bit array reads
// - mode bit 26 enables opcode loop optimisation
// - command word holds key 31:24, argument 23:8, code 7:0
// - only key 0x5a lets a command take effect
// - status bit 0 is ready, low while a command runs
// - bad code or key sets command error; status read or command write clears
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module flash_controller
    import flash_ctl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic rd_req,
    input wire logic [20:0] rd_addr,
    output logic rd_ready,
    output logic rd_valid,
    output logic [127:0] rd_data,
    input wire logic page_wr,
    input wire logic [8:0] page_addr,
    input wire logic [31:0] page_data,
    output logic arr_rd,
    output logic [20:0] arr_addr,
    output logic arr_wide,
    input wire logic [127:0] arr_rdata,
    input wire flash_ctl_pkg::ecc_flags_s arr_ecc,
    output logic macro_cmd_valid,
    output flash_ctl_pkg::cmd_word_s macro_cmd,
    input wire logic macro_done,
    input wire logic macro_fail,
    input wire logic [31:0] macro_result,
    output logic seq_prefetch_disable,
    output logic loop_opt_enable,
    output logic ready_irq,
    output logic ready_flag
);
    import flash_ctl_pkg::*;

    // ========================================
    // axi4-lite slave
    logic aw_hold, w_hold;
    logic [31:0] aw_addr_q, w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] mode_q, result_q;
    logic cmd_err, verr;
    logic [3:0] ecc_q;
    ctl_state_e state, next_state;

    wire aw_fire = awvalid & awready;
    wire w_fire = wvalid & wready;
    wire ar_fire = arvalid & arready;
    wire wr_commit = aw_hold & w_hold & ~bvalid;
    wire next_aw_hold = (aw_hold | aw_fire) & ~wr_commit;
    wire next_w_hold = (w_hold | w_fire) & ~wr_commit;
    wire next_rvalid = ar_fire | (rvalid & ~rready);
    // base compare keeps aliases of other system blocks off this slave
    wire w_in = aw_addr_q[31:8] == BASE_ADDR[31:8];
    wire r_in = araddr[31:8] == BASE_ADDR[31:8];
    wire [7:0] woff = aw_addr_q[7:0];
    wire [7:0] roff = araddr[7:0];
    wire w_ok = w_in & (woff == OFS_MODE || woff == OFS_CMD || woff == OFS_STATUS
        || woff == OFS_RESULT);
    wire r_ok = r_in & (roff == OFS_MODE || roff == OFS_CMD || roff == OFS_STATUS
        || roff == OFS_RESULT);
    wire [31:0] byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
        {8{w_strb_q[0]}}};
    wire mode_wr = wr_commit & w_in & woff == OFS_MODE;
    wire [31:0] mode_mask = byte_mask & MODE_MASK;
    wire [31:0] status_word = {12'h000, ecc_q, 12'h000, verr, 1'b0, cmd_err, ready_flag};
    wire status_rd = ar_fire & r_in & roff == OFS_STATUS;
    wire [31:0] rd_word = ~r_ok ? 32'h0 :
        roff == OFS_MODE ? mode_q :
        roff == OFS_STATUS ? status_word :
        roff == OFS_RESULT ? result_q : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
            aw_addr_q <= 32'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end
        else
        begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            awready <= ~next_aw_hold;
            wready <= ~next_w_hold;
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (aw_fire)
                aw_addr_q <= awaddr;
            if (w_fire)
            begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_commit)
            begin
                bvalid <= 1'b1;
                bresp <= w_ok ? RESP_OKAY : RESP_DECERR;
            end
            else if (bready)
                bvalid <= 1'b0;
            if (ar_fire)
            begin
                rdata <= rd_word;
                rresp <= r_ok ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // ========================================
    // command decode
    cmd_word_s cmd;
    assign cmd = cmd_word_s'(w_data_q);
    wire cmd_wr = wr_commit & w_in & woff == OFS_CMD;
    wire key_ok = cmd.write_key == KEY_VALUE;
    wire code_ok = cmd.command_code <= CMD_SIG_END;
    wire state_ok = state == C_IDLE
        | (state == C_SIG_MODE & cmd.command_code == CMD_SIG_END);
    wire cmd_go = cmd_wr & key_ok & code_ok & state_ok;
    wire cmd_bad = cmd_wr & ~cmd_go;
    wire go_macro = cmd_go & cmd.command_code <= CMD_MACRO_LAST;
    wire go_prog = cmd_go & cmd.command_code == CMD_SIG_PROGRAM;
    wire go_erase = cmd_go & cmd.command_code == CMD_SIG_ERASE;
    wire [3:0] wait_states = mode_q[MODE_WAIT_LSB +: 4];

    // ========================================
    // signature store and page buffer
    logic [31:0] sig_store [SIG_WORDS];
    logic [31:0] page_buf [SIG_WORDS];
    logic [6:0] idx;
    logic [3:0] wcnt;
    logic erase_op, sig_map;
    wire word_step = (state == C_PROG || state == C_ERASE) && wcnt == 4'h0;
    wire [31:0] expect_word = erase_op ? ERASED_WORD : page_buf[idx];
    wire verify_miss = state == C_VERIFY && sig_store[idx] != expect_word;

    // one word per wait_states+1 cycles while storing, one per cycle while verifying
    always_ff @(posedge aclk)
    begin
        if (page_wr)
            page_buf[page_addr[8:2]] <= page_data;
        if (word_step)
            sig_store[idx] <= erase_op ? ERASED_WORD : page_buf[idx];
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            C_IDLE:
            begin
                if (cmd_go)
                begin
                    if (go_prog)
                        next_state = C_PROG;
                    else if (go_erase)
                        next_state = C_ERASE;
                    else if (cmd.command_code == CMD_SIG_BEGIN)
                        next_state = C_SIG_MODE;
                    else if (cmd.command_code == CMD_SIG_END)
                        next_state = C_SWITCH;
                    else
                        next_state = C_MACRO;
                end
            end
            C_SIG_MODE:
            begin
                if (cmd_go)
                    next_state = C_SWITCH;
            end
            C_PROG, C_ERASE:
            begin
                if (word_step && idx == 7'h7f)
                    next_state = C_VERIFY;
            end
            C_VERIFY:
            begin
                if (idx == 7'h7f)
                    next_state = C_IDLE;
            end
            C_MACRO:
            begin
                if (macro_done)
                    next_state = C_IDLE;
            end
            C_SWITCH:
                next_state = C_IDLE;
            default:
                next_state = C_IDLE;
        endcase
    end

    wire next_ready = next_state == C_IDLE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= C_IDLE;
            ready_flag <= STATUS_RESET[ST_READY_BIT];
            ready_irq <= 1'b0;
            sig_map <= 1'b0;
            idx <= 7'h0;
            wcnt <= 4'h0;
            erase_op <= 1'b0;
            macro_cmd_valid <= 1'b0;
            macro_cmd <= '0;
            result_q <= RESULT_RESET;
        end
        else
        begin
            state <= next_state;
            ready_flag <= next_ready;
            ready_irq <= mode_q[MODE_IRQ_BIT] & next_ready;
            sig_map <= state == C_SIG_MODE;
            macro_cmd_valid <= go_macro;
            if (go_macro)
                macro_cmd <= cmd;
            if (state == C_MACRO && macro_done)
                result_q <= macro_result;
            else if (cmd_go && !go_macro)
                result_q <= RESULT_RESET;
            if (cmd_go)
            begin
                idx <= 7'h0;
                wcnt <= wait_states;
                erase_op <= go_erase;
            end
            else if (word_step)
            begin
                idx <= idx + 7'h1;
                wcnt <= wait_states;
            end
            else if (state == C_VERIFY)
                idx <= idx + 7'h1;
            else if (wcnt != 4'h0)
                wcnt <= wcnt - 4'h1;
        end
    end

    // ========================================
    // mode register and status flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q <= MODE_RESET;
            cmd_err <= STATUS_RESET[ST_CMDERR_BIT];
            verr <= STATUS_RESET[ST_VERR_BIT];
            seq_prefetch_disable <= MODE_RESET[MODE_SEQ_BIT];
            loop_opt_enable <= MODE_RESET[MODE_LOOP_BIT];
        end
        else
        begin
            if (mode_wr)
                mode_q <= (mode_q & ~mode_mask) | (w_data_q & mode_mask);
            seq_prefetch_disable <= mode_q[MODE_SEQ_BIT];
            loop_opt_enable <= mode_q[MODE_LOOP_BIT];
            // a new error wins over a clear in the same cycle
            cmd_err <= cmd_bad | (cmd_err & ~cmd_wr & ~status_rd);
            verr <= verify_miss | (state == C_MACRO & macro_done & macro_fail)
                | (verr & ~(go_prog | go_erase | go_macro));
        end
    end

    // ========================================
    // array read path
    logic rd_busy, from_sig, rd_wide;
    logic [3:0] rd_cnt;
    wire rd_take = rd_req & rd_ready;
    wire map_hit = sig_map & rd_addr[20:9] == 12'h000;
    wire rd_last = rd_busy & rd_cnt == 4'h0;
    wire next_rd_busy = rd_take | (rd_busy & ~rd_last);
    wire [4:0] line = arr_addr[8:4];
    wire [127:0] sig_line = {sig_store[{line, 2'h3}], sig_store[{line, 2'h2}],
        sig_store[{line, 2'h1}], sig_store[{line, 2'h0}]};
    wire [127:0] src_line = from_sig ? sig_line : arr_rdata;
    wire [63:0] half = arr_addr[3] ? src_line[127:64] : src_line[63:0];
    wire [127:0] shaped = rd_wide ? src_line : {64'h0, half};
    wire hi_seen = rd_wide | arr_addr[3];
    wire lo_seen = rd_wide | ~arr_addr[3];
    wire [3:0] ecc_set = {4{rd_last & ~from_sig}}
        & {{2{hi_seen}}, {2{lo_seen}}} & arr_ecc;

    // flags carry no address: prefetch may have raised them
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ecc
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    ecc_q[g] <= STATUS_RESET[ST_ECC_LSB + g];
                else
                    ecc_q[g] <= ecc_set[g] | (ecc_q[g] & ~status_rd);
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_busy <= 1'b0;
            rd_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 128'h0;
            rd_cnt <= 4'h0;
            from_sig <= 1'b0;
            rd_wide <= 1'b0;
            arr_rd <= 1'b0;
            arr_addr <= 21'h0;
            arr_wide <= 1'b0;
        end
        else
        begin
            rd_busy <= next_rd_busy;
            rd_ready <= ~next_rd_busy;
            rd_valid <= rd_last;
            arr_rd <= (rd_take & ~map_hit) | (arr_rd & ~rd_last);
            if (rd_take)
            begin
                rd_cnt <= wait_states;
                from_sig <= map_hit;
                rd_wide <= ~mode_q[MODE_WIDTH_BIT];
                arr_wide <= ~mode_q[MODE_WIDTH_BIT];
                arr_addr <= rd_addr;
            end
            else if (rd_busy)
                rd_cnt <= rd_cnt - 4'h1;
            if (rd_last)
                rd_data <= shaped;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [4:0] lat;
    logic [3:0] wait_take;
    always_ff @(posedge aclk)
    begin
        lat <= rd_take ? 5'h0 : lat + 5'h1;
        if (rd_take)
            wait_take <= wait_states;
    end

    // the end-of-signature switch is a single busy cycle, checked by p_end_seq
    property p_ready_drop;
        cmd_go && cmd.command_code != CMD_SIG_END |=> !ready_flag [*2];
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready not low after command");

    property p_bad_key;
        cmd_wr && !key_ok |=> $stable(state) && !macro_cmd_valid;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key started work");

    property p_irq;
        ready_irq == (ready_flag && $past(mode_q[MODE_IRQ_BIT]));
    endproperty
    a_irq: assert property (p_irq) else $error("ready interrupt mismatch");

    property p_wait_states;
        rd_valid |-> lat == {1'b0, wait_take} + 5'h1;
    endproperty
    a_wait_states: assert property (p_wait_states) else $error("read length wrong");

    property p_map_after_drop;
        $rose(sig_map) |-> !ready_flag && $past(!ready_flag);
    endproperty
    a_map_after_drop: assert property (p_map_after_drop) else $error("mapped before ready fell");

    property p_end_seq;
        state == C_SIG_MODE && cmd_go |=> ##1 ready_flag && !sig_map;
    endproperty
    a_end_seq: assert property (p_end_seq) else $error("signature end did not finish");

    property p_ecc_hold;
        !status_rd |=> (ecc_q & $past(ecc_q)) == $past(ecc_q);
    endproperty
    a_ecc_hold: assert property (p_ecc_hold) else $error("ecc flag lost");

    property p_cmd_err;
        cmd_bad |=> cmd_err ##1 (cmd_err || $past(status_rd || cmd_wr));
    endproperty
    a_cmd_err: assert property (p_cmd_err) else $error("command error not flagged");

    property p_verify;
        verify_miss |=> verr && !ready_flag;
    endproperty
    a_verify: assert property (p_verify) else $error("verify failure missed");

    property p_narrow;
        rd_valid && !$past(rd_wide) |-> rd_data[127:64] == 64'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow read too wide");

    c_sig_read: cover property (state == C_SIG_MODE && rd_take && map_hit ##[1:20] rd_valid);
    c_prog_done: cover property (state == C_VERIFY ##1 state == C_IDLE);
    c_ecc_seen: cover property (ecc_set != 4'h0 ##1 status_rd);
    c_bad_cmd: cover property (cmd_bad ##1 ready_flag);
endmodule

// >>> flash_ctl_pkg.sv
// shared constants and types of the embedded flash command controller
package flash_ctl_pkg;
    // ========================================
    // register map
    localparam logic [31:0] BASE_ADDR = 32'h400e0a00;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ========================================
    // flash_mode_control fields
    localparam int MODE_IRQ_BIT = 0;
    localparam int MODE_WAIT_LSB = 8;
    localparam int MODE_SEQ_BIT = 16;
    localparam int MODE_WIDTH_BIT = 24;
    localparam int MODE_LOOP_BIT = 26;
    localparam logic [31:0] MODE_RESET = 32'h04000000;
    localparam logic [31:0] MODE_MASK = 32'h05010f01;
    // ========================================
    // flash_controller_status fields
    localparam int ST_READY_BIT = 0;
    localparam int ST_CMDERR_BIT = 1;
    localparam int ST_VERR_BIT = 3;
    localparam int ST_ECC_LSB = 16;
    localparam logic [31:0] STATUS_RESET = 32'h00000001;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    // ========================================
    // command word
    localparam logic [7:0] KEY_VALUE = 8'h5a;
    localparam logic [7:0] CMD_MACRO_LAST = 8'h11;
    localparam logic [7:0] CMD_SIG_PROGRAM = 8'h12;
    localparam logic [7:0] CMD_SIG_ERASE = 8'h13;
    localparam logic [7:0] CMD_SIG_BEGIN = 8'h14;
    localparam logic [7:0] CMD_SIG_END = 8'h15;
    localparam int SIG_WORDS = 128;
    localparam logic [31:0] ERASED_WORD = 32'hffffffff;

    typedef struct packed {
        logic [7:0] write_key;
        logic [15:0] command_argument;
        logic [7:0] command_code;
    } cmd_word_s;

    typedef struct packed {
        logic high_half_uncorrectable_flag;
        logic high_half_corrected_flag;
        logic low_half_uncorrectable_flag;
        logic low_half_corrected_flag;
    } ecc_flags_s;

    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_SIG_MODE = 3'b001,
        C_PROG = 3'b010,
        C_ERASE = 3'b011,
        C_VERIFY = 3'b100,
        C_MACRO = 3'b101,
        C_SWITCH = 3'b110
    } ctl_state_e;
endpackage

// >>> tb_embedded_flash_command_controller.sv
// self-checking testbench of the flash command controller
`timescale 1ns/1ps
module tb_embedded_flash_command_controller;
    import flash_ctl_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, rd_req = 1'b0, page_wr = 1'b0, fail_inj = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, page_data = '0, rdata, macro_result;
    logic [3:0] wstrb = '0, ecc_inj = '0;
    logic [20:0] rd_addr = '0, arr_addr;
    logic [8:0] page_addr = '0;
    logic awready, wready, bvalid, arready, rvalid, rd_ready, rd_valid, arr_rd, arr_wide;
    logic macro_cmd_valid, macro_done, macro_fail, seq_prefetch_disable, loop_opt_enable;
    logic ready_irq, ready_flag;
    logic [1:0] bresp, rresp;
    logic [127:0] rd_data, arr_rdata;
    ecc_flags_s arr_ecc;
    cmd_word_s macro_cmd;
    int fails = 0, total_checks = 0;
    always #2 aclk = ~aclk;
    flash_controller u_dut (.*);
    flash_array_model u_array (.*);
    // ========================================
    // checking and closing
    function automatic logic [127:0] pat(input logic [20:0] a);
        logic [31:0] x;
        x = {11'h0, a};
        return {x + 32'h3, x + 32'h2, x + 32'h1, x};
    endfunction
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 3000)
        begin
            fails++;
            final_report();
        end
    endtask
    // ========================================
    // bus tasks; each starts one edge after the last so no signal is driven twice per step
    task automatic wr(input logic [7:0] o, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= BASE_ADDR | {24'h0, o};
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid && n < 3000);
        bready <= 1'b0;
        tmo(n);
        chk("bresp", er, bresp);
    endtask
    task automatic rd(input logic [7:0] o, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= BASE_ADDR | {24'h0, o};
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid && n < 3000);
        rready <= 1'b0;
        tmo(n);
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(OFS_CMD, {KEY_VALUE, 16'h0, c}, RESP_OKAY);
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        while (ready_flag !== 1'b1 && n < 3000)
        begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
    endtask
    task automatic frd(input logic [20:0] a, input logic [127:0] e, input int w);
        int n;
        @(posedge aclk);
        rd_req <= 1'b1;
        rd_addr <= a;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!rd_ready && n < 3000);
        rd_req <= 1'b0;
        tmo(n);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!rd_valid && n < 3000);
        tmo(n);
        chk("read latency", w + 2, n);
        chk("rd_data", e, rd_data);
    endtask
    // ========================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_MODE, MODE_RESET, RESP_OKAY);
        rd(OFS_STATUS, STATUS_RESET, RESP_OKAY);
        rd(OFS_RESULT, RESULT_RESET, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_DECERR);
        wr(8'h10, 32'hffffffff, RESP_DECERR);
        wr(OFS_MODE, 32'hffffffff, RESP_OKAY);
        rd(OFS_MODE, MODE_MASK, RESP_OKAY);
        chk("prefetch disable", 1, seq_prefetch_disable);
        chk("loop opt", 1, loop_opt_enable);
        chk("ready irq", 1, ready_irq);
        frd(21'h1000, pat(21'h1000) & {64'h0, {64{1'b1}}}, 15);
        chk("arr_wide", 0, arr_wide);
        for (int w = 0; w < 4; w += 3)
        begin
            wr(OFS_MODE, 32'h04000001 | (w << 8), RESP_OKAY);
            @(posedge aclk);
            chk("prefetch disable", 0, seq_prefetch_disable);
            frd(21'h2000 + 21'(w * 16), pat(21'h2000 + 21'(w * 16)), w);
        end
        ecc_inj <= 4'h5;
        frd(21'h3000, pat(21'h3000), 3);
        ecc_inj <= 4'h0;
        rd(OFS_STATUS, 32'h00050001, RESP_OKAY);
        rd(OFS_STATUS, 32'h00000001, RESP_OKAY);
        wr(OFS_CMD, {8'h00, 16'h0, CMD_SIG_ERASE}, RESP_OKAY);
        chk("ready after bad key", 1, ready_flag);
        rd(OFS_STATUS, 32'h00000003, RESP_OKAY);
        cmd(8'h16);
        rd(OFS_STATUS, 32'h00000003, RESP_OKAY);
        for (int i = 0; i < SIG_WORDS; i++)
        begin
            page_wr <= 1'b1;
            page_addr <= 9'(i * 4);
            page_data <= 32'h51000000 + i;
            @(posedge aclk);
        end
        page_wr <= 1'b0;
        cmd(CMD_SIG_PROGRAM);
        chk("busy ready", 0, ready_flag);
        chk("busy irq", 0, ready_irq);
        cmd(CMD_SIG_ERASE);
        wait_rdy();
        rd(OFS_STATUS, 32'h00000003, RESP_OKAY);
        // only signature reads between begin and end: no fetch from the array meanwhile
        cmd(CMD_SIG_BEGIN);
        ecc_inj <= 4'hf;
        frd(21'h10, {32'h51000007, 32'h51000006, 32'h51000005, 32'h51000004}, 3);
        ecc_inj <= 4'h0;
        chk("ready in signature mode", 0, ready_flag);
        cmd(CMD_SIG_END);
        wait_rdy();
        chk("irq after end", 1, ready_irq);
        rd(OFS_STATUS, 32'h00000001, RESP_OKAY);
        cmd(CMD_SIG_ERASE);
        wait_rdy();
        cmd(CMD_SIG_BEGIN);
        frd(21'h1f0, {4{ERASED_WORD}}, 3);
        cmd(CMD_SIG_END);
        wait_rdy();
        frd(21'h10, pat(21'h10), 3);
        for (int c = 0; c < 18; c++)
        begin
            fail_inj <= (c == 17);
            cmd(8'(c));
            wait_rdy();
            rd(OFS_RESULT, {24'hc0de00, 8'(c)}, RESP_OKAY);
        end
        rd(OFS_STATUS, 32'h00000009, RESP_OKAY);
        final_report();
    end
endmodule
